/* File: usmf_ctrl.sv */
// Mode, flow control, guard time and prescaler control of a serial port, on AXI4-Lite.
`default_nettype none
`include "usmf_params.svh"
module usmf_ctrl
  import usmf_pkg::*;
#(
  parameter int REDUCED = 0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AXI4-Lite write address.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`USMF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data.
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`USMF_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data.
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Modem pins.
  input wire logic ctsN,
  output logic rtsN,
  // Frame engine side.
  input wire usmf_evt_s engineEvt,
  input wire logic rxReady,
  input wire usmf_dma_s dmaReqRaw,
  output usmf_dma_s dmaReq,
  output usmf_mode_s mode,
  output logic txAllowed,
  output logic transmitCompleteFlag,
  output logic irLowPowerTick,
  output logic smartcardClk,
  // Interrupt.
  output logic irq
);

  localparam logic [31:0] ModeMask = (REDUCED != 0) ? `USMF_MODE_FLOW_MASK_REDUCED :
                                                      `USMF_MODE_FLOW_MASK;
  localparam logic [31:0] GuardMask = (REDUCED != 0) ? `USMF_GUARD_PSC_MASK_REDUCED :
                                                       `USMF_GUARD_PSC_MASK;

  initial begin
    if (REDUCED != 0 && REDUCED != 1) begin
      $error("usmf_ctrl REDUCED must be 0 or 1");
    end
  end

  logic [31:0] modeFlow_ff;
  logic [31:0] guardPsc_ff;
  logic [`USMF_IRQ_W-1:0] irqStat_ff;
  logic [`USMF_IRQ_W-1:0] irqEn_ff;
  logic [`USMF_IRQ_W-1:0] irqSet;
  logic [`USMF_IRQ_W-1:0] irqClr;
  logic [`USMF_IRQ_W-1:0] irqGate;
  logic awHeld_ff;
  logic wHeld_ff;
  logic [`USMF_ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  logic doWrite;
  logic [1:0] nxt_bResp;
  logic [31:0] nxt_rData;
  logic [1:0] nxt_rResp;
  logic ctsMeta_ff;
  logic ctsSync_ff;
  logic ctsLast_ff;
  logic [1:0] ctsWarm_ff;
  logic ctsChange;
  logic rtsN_ff;
  usmf_dma_s dmaReq_ff;
  usmf_guard_e guardState_ff;
  logic [7:0] guardCnt_ff;
  logic tcPulse_ff;
  logic scTick;
  logic lpTick;
  logic [7:0] lpDivisor;
  logic [7:0] scDivisor;

  // Control fields.
  logic ctsIrqEn;
  logic ctsFlowEn;
  logic rtsFlowEn;
  logic txDmaEn;
  logic rxDmaEn;
  logic errIrqEn;
  logic [7:0] guardTime;
  logic [7:0] prescale;

  assign ctsIrqEn = modeFlow_ff[`USMF_BIT_CTS_IRQ_EN];
  assign ctsFlowEn = modeFlow_ff[`USMF_BIT_CTS_FLOW];
  assign rtsFlowEn = modeFlow_ff[`USMF_BIT_RTS_FLOW];
  assign txDmaEn = modeFlow_ff[`USMF_BIT_TX_DMA];
  assign rxDmaEn = modeFlow_ff[`USMF_BIT_RX_DMA];
  assign errIrqEn = modeFlow_ff[`USMF_BIT_ERR_IRQ_EN];
  assign guardTime = guardPsc_ff[`USMF_GUARD_MSB:`USMF_GUARD_LSB];
  assign prescale = guardPsc_ff[`USMF_PSC_MSB:`USMF_PSC_LSB];

  // Write channel: address and data are taken in either order, then one response.
  assign s_axi_awready = !awHeld_ff && !bValid_ff;
  assign s_axi_wready = !wHeld_ff && !bValid_ff;
  assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wHeld_ff <= 1'b0;
      wData_ff <= '0;
      wStrb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_bResp = `USMF_RESP_OKAY;
    unique case (awAddr_ff)
      `USMF_OFS_MODE_FLOW, `USMF_OFS_GUARD_PSC, `USMF_OFS_IRQ_CLR, `USMF_OFS_IRQ_EN: begin
        nxt_bResp = `USMF_RESP_OKAY;
      end
      default: begin
        nxt_bResp = `USMF_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bValid_ff <= 1'b0;
      bResp_ff <= `USMF_RESP_OKAY;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      bResp_ff <= nxt_bResp;
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // Partial writes to the mode and guard time registers are dropped rather than merged.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      modeFlow_ff <= `USMF_MODE_FLOW_RESET;
    end else if (doWrite && awAddr_ff == `USMF_OFS_MODE_FLOW && wStrb_ff == 4'hF) begin
      modeFlow_ff <= wData_ff & ModeMask;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      guardPsc_ff <= `USMF_GUARD_PSC_RESET;
    end else if (doWrite && awAddr_ff == `USMF_OFS_GUARD_PSC && wStrb_ff == 4'hF) begin
      guardPsc_ff <= wData_ff & GuardMask;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqEn_ff <= `USMF_IRQ_RESET;
    end else if (doWrite && awAddr_ff == `USMF_OFS_IRQ_EN && wStrb_ff[0]) begin
      irqEn_ff <= wData_ff[`USMF_IRQ_W-1:0];
    end
  end

  assign irqClr = (doWrite && awAddr_ff == `USMF_OFS_IRQ_CLR && wStrb_ff[0]) ?
                  wData_ff[`USMF_IRQ_W-1:0] : '0;

  // Read channel answers one cycle after the address is taken.
  assign s_axi_arready = !rValid_ff;

  always_comb begin
    nxt_rData = '0;
    nxt_rResp = `USMF_RESP_OKAY;
    unique case (s_axi_araddr)
      `USMF_OFS_MODE_FLOW: begin
        nxt_rData = modeFlow_ff;
      end
      `USMF_OFS_GUARD_PSC: begin
        nxt_rData = guardPsc_ff;
      end
      `USMF_OFS_IRQ_STAT: begin
        nxt_rData = {29'h0, irqStat_ff};
      end
      `USMF_OFS_IRQ_EN: begin
        nxt_rData = {29'h0, irqEn_ff};
      end
      `USMF_OFS_IRQ_CLR: begin
        nxt_rData = '0;
      end
      default: begin
        nxt_rResp = `USMF_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= `USMF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_ff <= 1'b1;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

  // Clear-to-send is synchronised; edges count only once the chain holds real pin samples.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctsMeta_ff <= 1'b1;
      ctsSync_ff <= 1'b1;
      ctsLast_ff <= 1'b1;
      ctsWarm_ff <= 2'h0;
    end else begin
      ctsMeta_ff <= ctsN;
      ctsSync_ff <= ctsMeta_ff;
      ctsLast_ff <= ctsSync_ff;
      ctsWarm_ff <= ctsWarm_ff + {1'b0, ctsWarm_ff != 2'h3};
    end
  end

  assign ctsChange = (ctsSync_ff ^ ctsLast_ff) && ctsWarm_ff == 2'h3;
  assign txAllowed = !ctsFlowEn || !ctsSync_ff;

  // With flow control off the line is held asserted so the partner never stalls.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rtsN_ff <= 1'b1;
    end else begin
      rtsN_ff <= rtsFlowEn ? !rxReady : 1'b0;
    end
  end

  assign rtsN = rtsN_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dmaReq_ff <= '0;
    end else begin
      dmaReq_ff.txReq <= dmaReqRaw.txReq && txDmaEn;
      dmaReq_ff.rxReq <= dmaReqRaw.rxReq && rxDmaEn;
    end
  end

  assign dmaReq = dmaReq_ff;

  // Mode selections handed to the frame engine.
  assign mode.smartcard = modeFlow_ff[`USMF_BIT_SMARTCARD];
  assign mode.nackOnParity = modeFlow_ff[`USMF_BIT_SMARTCARD] &&
                             modeFlow_ff[`USMF_BIT_NACK_EN];
  assign mode.halfDuplex = modeFlow_ff[`USMF_BIT_HALF_DUPLEX];
  assign mode.irEnable = modeFlow_ff[`USMF_BIT_IR_EN];
  assign mode.irLowPower = modeFlow_ff[`USMF_BIT_IR_EN] &&
                           modeFlow_ff[`USMF_BIT_IR_LOW_POWER];

  // In smartcard mode the guard time holds back transmit complete by whole baud periods.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      guardState_ff <= GT_IDLE;
      guardCnt_ff <= '0;
      tcPulse_ff <= 1'b0;
    end else begin
      tcPulse_ff <= 1'b0;
      unique case (guardState_ff)
        GT_IDLE: begin
          if (engineEvt.txFrameDone) begin
            if (mode.smartcard && guardTime != 8'h00) begin
              guardState_ff <= GT_WAIT;
              guardCnt_ff <= guardTime;
            end else begin
              tcPulse_ff <= 1'b1;
            end
          end
        end
        GT_WAIT: begin
          if (engineEvt.baudTick) begin
            if (guardCnt_ff == 8'h01) begin
              guardState_ff <= GT_IDLE;
              tcPulse_ff <= 1'b1;
            end
            guardCnt_ff <= guardCnt_ff - 8'h01;
          end
        end
      endcase
    end
  end

  assign transmitCompleteFlag = tcPulse_ff;

  // Dividers: the smartcard path sees only the low five prescaler bits.
  assign lpDivisor = prescale;
  assign scDivisor = {3'h0, prescale[`USMF_SC_PSC_MSB:0]};

  usmf_clk_div #(
    .W(8)
  ) u_lp_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(mode.irLowPower),
    .divisor(lpDivisor),
    .tick(lpTick),
    .clkOut()
  );

  usmf_clk_div #(
    .W(8)
  ) u_sc_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(mode.smartcard),
    .divisor(scDivisor),
    .tick(scTick),
    .clkOut(smartcardClk)
  );

  assign irLowPowerTick = lpTick;

  // Sticky event bits; a set in the same cycle as a clear wins.
  assign irqSet[`USMF_IRQ_CTS] = ctsChange;
  assign irqSet[`USMF_IRQ_ERR] = engineEvt.framingErr || engineEvt.overrunErr ||
                                 engineEvt.noiseErr;
  assign irqSet[`USMF_IRQ_TC] = tcPulse_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_ff <= `USMF_IRQ_RESET;
    end else begin
      irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
    end
  end

  assign irqGate[`USMF_IRQ_CTS] = ctsIrqEn;
  assign irqGate[`USMF_IRQ_ERR] = errIrqEn && rxDmaEn;
  assign irqGate[`USMF_IRQ_TC] = 1'b1;
  assign irq = |(irqStat_ff & irqEn_ff & irqGate);

endmodule
`default_nettype wire

/* File: usmf_params.svh */
// Register offsets, field positions, reset values and masks of the mode and prescaler block.
`ifndef USMF_PARAMS_SVH
`define USMF_PARAMS_SVH

`define USMF_ADDR_W 8
`define USMF_OFS_MODE_FLOW 8'h14
`define USMF_OFS_GUARD_PSC 8'h18
`define USMF_OFS_IRQ_STAT 8'h20
`define USMF_OFS_IRQ_CLR 8'h24
`define USMF_OFS_IRQ_EN 8'h28

`define USMF_BIT_ERR_IRQ_EN 0
`define USMF_BIT_IR_EN 1
`define USMF_BIT_IR_LOW_POWER 2
`define USMF_BIT_HALF_DUPLEX 3
`define USMF_BIT_NACK_EN 4
`define USMF_BIT_SMARTCARD 5
`define USMF_BIT_RX_DMA 6
`define USMF_BIT_TX_DMA 7
`define USMF_BIT_RTS_FLOW 8
`define USMF_BIT_CTS_FLOW 9
`define USMF_BIT_CTS_IRQ_EN 10

`define USMF_MODE_FLOW_RESET 32'h00000000
`define USMF_GUARD_PSC_RESET 32'h00000000
`define USMF_MODE_FLOW_MASK 32'h000007FF
`define USMF_MODE_FLOW_MASK_REDUCED 32'h000000CF
`define USMF_GUARD_PSC_MASK 32'h0000FFFF
`define USMF_GUARD_PSC_MASK_REDUCED 32'h000000FF

`define USMF_PSC_LSB 0
`define USMF_PSC_MSB 7
`define USMF_SC_PSC_MSB 4
`define USMF_GUARD_LSB 8
`define USMF_GUARD_MSB 15

`define USMF_IRQ_W 3
`define USMF_IRQ_CTS 0
`define USMF_IRQ_ERR 1
`define USMF_IRQ_TC 2
`define USMF_IRQ_RESET 3'h0

`define USMF_RESP_OKAY 2'h0
`define USMF_RESP_SLVERR 2'h2

`endif

/* File: usmf_pkg.sv */
// Types shared by the mode and prescaler block.
`default_nettype none
package usmf_pkg;

  typedef struct packed {
    logic smartcard;
    logic nackOnParity;
    logic halfDuplex;
    logic irEnable;
    logic irLowPower;
  } usmf_mode_s;

  typedef struct packed {
    logic framingErr;
    logic overrunErr;
    logic noiseErr;
    logic txFrameDone;
    logic baudTick;
  } usmf_evt_s;

  typedef struct packed {
    logic txReq;
    logic rxReq;
  } usmf_dma_s;

  typedef enum logic [0:0] {GT_IDLE, GT_WAIT} usmf_guard_e;

endpackage
`default_nettype wire

/* File: usmf_clk_div.sv */
// Programmable divider giving a one-cycle tick every divisor cycles and a toggled clock.
`default_nettype none
module usmf_clk_div #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control.
  input wire logic enable,
  input wire logic [W-1:0] divisor,
  // Outputs.
  output logic tick,
  output logic clkOut
);

  logic [W-1:0] cnt_ff;
  logic tick_ff;
  logic clk_ff;

  initial begin
    if (W < 1) begin
      $error("usmf_clk_div needs W of at least 1");
    end
  end

  // A zero divisor is reserved, so the divider simply stays idle on it.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (!enable || divisor == '0) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff + W'(1) >= divisor) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      clk_ff <= 1'b0;
    end else if (!enable || divisor == '0) begin
      clk_ff <= 1'b0;
    end else if (tick_ff) begin
      clk_ff <= ~clk_ff;
    end
  end

  assign tick = tick_ff;
  assign clkOut = clk_ff;

endmodule
`default_nettype wire

/* File: usmf_ctrl_properties.sv */
// Concurrent checks on the port behaviour of the mode and prescaler block.
`default_nettype none
module usmf_ctrl_properties
  import usmf_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Modem pins.
  input wire logic ctsN,
  input wire logic rtsN,
  // Frame engine side.
  input wire usmf_evt_s engineEvt,
  input wire logic rxReady,
  input wire usmf_dma_s dmaReqRaw,
  input wire usmf_dma_s dmaReq,
  input wire usmf_mode_s mode,
  input wire logic txAllowed,
  input wire logic transmitCompleteFlag,
  input wire logic irLowPowerTick,
  input wire logic smartcardClk
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Outside smartcard mode no guard wait applies, so completion follows at once.
  sequence s_plain_done;
    engineEvt.txFrameDone && !mode.smartcard;
  endsequence

  a_plain_tc: assert property (s_plain_done |=> transmitCompleteFlag)
    else $error("transmit complete missing after a plain frame");
  a_tc_cause: assert property (transmitCompleteFlag |->
    $past(engineEvt.txFrameDone) || $past(engineEvt.baudTick))
    else $error("transmit complete without frame end or baud tick");
  // The pin passes two synchroniser stages before it may stop the sender.
  a_cts_gate: assert property (!txAllowed |-> $past(ctsN, 2))
    else $error("transmitter stopped while the modem was clear");
  a_rts_follow: assert property (rtsN && !$past(sys_rst) |-> !$past(rxReady))
    else $error("request to send withdrawn while receiver ready");
  a_tx_dma_gate: assert property (dmaReq.txReq |-> $past(dmaReqRaw.txReq))
    else $error("transmit dma request without a raw request");
  a_rx_dma_gate: assert property (dmaReq.rxReq |-> $past(dmaReqRaw.rxReq))
    else $error("receive dma request without a raw request");
  a_nack_sc_only: assert property (mode.nackOnParity |-> mode.smartcard)
    else $error("nack enabled outside smartcard mode");
  a_lowpower_ir: assert property (mode.irLowPower |-> mode.irEnable)
    else $error("infrared low power without infrared mode");
  a_lp_tick_mode: assert property (irLowPowerTick |-> $past(mode.irLowPower))
    else $error("low power tick outside low power mode");
  a_scclk_mode: assert property (smartcardClk |-> $past(mode.smartcard))
    else $error("card clock running outside smartcard mode");
endmodule

bind usmf_ctrl usmf_ctrl_properties usmf_ctrl_properties_i (
  .clk_sys, .sys_rst, .ctsN, .rtsN, .engineEvt, .rxReady, .dmaReqRaw, .dmaReq, .mode,
  .txAllowed, .transmitCompleteFlag, .irLowPowerTick, .smartcardClk
);
`default_nettype wire

/* File: usmf_line_model.sv */
// Stand-in for the modem line and frame engine: clear to send, baud ticks and frame events.
`default_nettype none
module usmf_line_model
  import usmf_pkg::*;
#(
  parameter int BAUD = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Commands from the bench.
  input wire logic holdOff,
  input wire logic frameReq,
  input wire logic [2:0] errReq,
  // Line side.
  output logic ctsN,
  output usmf_evt_s engineEvt
);
  timeunit 1ns;
  timeprecision 100ps;
  int baudCnt_ff;
  logic pend_ff;

  // A frame ends on the cycle after a baud tick, so the guard wait starts on a clean boundary.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      baudCnt_ff <= 0;
      pend_ff <= 1'b0;
      engineEvt <= '0;
      ctsN <= 1'b0;
    end else begin
      baudCnt_ff <= (baudCnt_ff == BAUD - 1) ? 0 : baudCnt_ff + 1;
      pend_ff <= (pend_ff || frameReq) && !(pend_ff && baudCnt_ff == 0);
      engineEvt.baudTick <= (baudCnt_ff == BAUD - 1);
      engineEvt.txFrameDone <= pend_ff && baudCnt_ff == 0;
      engineEvt.framingErr <= errReq[0];
      engineEvt.overrunErr <= errReq[1];
      engineEvt.noiseErr <= errReq[2];
      ctsN <= holdOff;
    end
  end
endmodule
`default_nettype wire

/* File: usmf_ctrl_tb.sv */
// Self-checking bench of the mode and prescaler block over its register bus.
`default_nettype none
`include "usmf_params.svh"
module usmf_ctrl_tb
  import usmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BAUD = 4;
  localparam logic [7:0] MF = `USMF_OFS_MODE_FLOW;
  localparam logic [7:0] GP = `USMF_OFS_GUARD_PSC;
  localparam logic [7:0] IS = `USMF_OFS_IRQ_STAT;
  localparam logic [7:0] IC = `USMF_OFS_IRQ_CLR;
  localparam logic [7:0] IE = `USMF_OFS_IRQ_EN;
  localparam logic [31:0] MODE_IN [7] = '{32'h20, 32'h30, 32'h10, 32'h08, 32'h02, 32'h06, 32'h04};
  localparam logic [4:0] MODE_OUT [7] = '{5'h10, 5'h18, 5'h00, 5'h04, 5'h02, 5'h03, 5'h00};

  logic clk_sys, sys_rst, irq, txAllowed, transmitCompleteFlag, irLowPowerTick, smartcardClk;
  logic ctsN, rtsN, rxReady, holdOff, frameReq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot, errReq;
  logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
  logic [31:0] rdReduced;
  usmf_evt_s engineEvt;
  usmf_dma_s dmaReqRaw, dmaReq;
  usmf_mode_s mode;
  int bad_count, n_compared, n;

  usmf_ctrl usmf_ctrl_i (
    .clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .ctsN, .rtsN, .engineEvt,
    .rxReady, .dmaReqRaw, .dmaReq, .mode, .txAllowed, .transmitCompleteFlag,
    .irLowPowerTick, .smartcardClk, .irq
  );

  // A reduced twin on the same bus shows which controls are absent there.
  usmf_ctrl #(.REDUCED(1)) usmf_ctrl_reduced_i (
    .clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready(), .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid(),
    .s_axi_bready, .s_axi_bresp(), .s_axi_arvalid, .s_axi_arready(), .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid(), .s_axi_rready, .s_axi_rdata(rdReduced), .s_axi_rresp(),
    .ctsN, .rtsN(), .engineEvt, .rxReady, .dmaReqRaw, .dmaReq(), .mode(), .txAllowed(),
    .transmitCompleteFlag(), .irLowPowerTick(), .smartcardClk(), .irq()
  );

  usmf_line_model #(.BAUD(BAUD)) usmf_line_model_i (
    .clk_sys, .sys_rst, .holdOff, .frameReq, .errReq, .ctsN, .engineEvt
  );

  always #2.5 clk_sys = ~clk_sys;

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
  endtask

  // Both response channels keep ready high throughout, which the bus allows.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    lastResp = s_axi_bresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
  endtask

  // Cycles from the end of a frame to the completion pulse.
  task automatic tc_gap(output int g);
    g = 0;
    frameReq <= 1'b1;
    @(posedge clk_sys);
    frameReq <= 1'b0;
    repeat (50) begin
      @(posedge clk_sys);
      if (engineEvt.txFrameDone) break;
    end
    repeat (100) begin
      @(posedge clk_sys);
      g++;
      if (transmitCompleteFlag) break;
    end
  endtask

  // Cycles between two rising edges of the low power tick or of the card clock.
  task automatic gap(input bit w, output int g);
    int t, first;
    logic p, c;
    t = 0;
    first = -1;
    g = 0;
    p = 1'b1;
    repeat (200) begin
      @(posedge clk_sys);
      t++;
      c = w ? smartcardClk : irLowPowerTick;
      if (c && !p && first >= 0 && g == 0) g = t - first;
      if (c && !p && first < 0) first = t;
      p = c;
    end
  endtask

  task automatic endt(input int k);
    $display("test %0d finished, %0d mismatches so far", k, bad_count);
  endtask

  task automatic complete_run();
    $display("%0d comparisons, %0d mismatches", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end

  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rxReady, holdOff, frameReq} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awprot, s_axi_arprot, errReq, dmaReqRaw} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    bad_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(2);
    rc(MF, 32'h0);
    rc(GP, 32'h0);
    wr(MF, 32'hFFFFFFFF);
    rc(MF, 32'h000007FF);
    chk(rdReduced, 32'h000000CF);
    wr(MF, 32'h0);
    wr(GP, 32'hFFFFFFFF);
    rc(GP, 32'h0000FFFF);
    chk(rdReduced, 32'h000000FF);
    wr(GP, 32'h0, 4'h3);
    rc(GP, 32'h0000FFFF);
    wr(8'h30, 32'h1);
    chk(32'(lastResp), 32'h2);
    rc(8'h30, 32'h0);
    chk(32'(s_axi_rresp), 32'h2);
    rc(IS, 32'h0);
    endt(1);
    dmaReqRaw <= '1;
    for (int i = 0; i < 4; i++) begin
      wr(MF, 32'(i) << 6);
      cyc(2);
      chk(32'(dmaReq), 32'(i));
    end
    dmaReqRaw <= '0;
    for (int i = 0; i < 4; i++) begin
      wr(MF, 32'(i / 2) << 8);
      rxReady <= i[0];
      cyc(3);
      chk(32'(rtsN), 32'(i == 2));
    end
    endt(2);
    wr(IE, 32'h7);
    wr(MF, 32'h200);
    wr(IC, 32'h7);
    rc(IS, 32'h0);
    holdOff <= 1'b1;
    cyc(6);
    chk(32'(txAllowed), 32'h0);
    chk(32'(irq), 32'h0);
    rc(IS, 32'h1);
    wr(MF, 32'h600);
    chk(32'(irq), 32'h1);
    wr(IC, 32'h1);
    chk(32'(irq), 32'h0);
    rc(IC, 32'h0);
    wr(MF, 32'h0);
    cyc(2);
    chk(32'(txAllowed), 32'h1);
    holdOff <= 1'b0;
    cyc(6);
    wr(IC, 32'h7);
    endt(3);
    for (int i = 0; i < 3; i++) begin
      wr(MF, 32'h1);
      errReq <= 3'h1 << i;
      @(posedge clk_sys);
      errReq <= 3'h0;
      cyc(3);
      chk(32'(irq), 32'h0);
      rc(IS, 32'h2);
      wr(MF, 32'h41);
      chk(32'(irq), 32'h1);
      wr(IC, 32'h2);
      chk(32'(irq), 32'h0);
    end
    endt(4);
    for (int i = 0; i < 7; i++) begin
      wr(MF, MODE_IN[i]);
      chk(32'(mode), 32'(MODE_OUT[i]));
    end
    endt(5);
    wr(GP, 32'h5);
    wr(MF, 32'h6);
    gap(1'b0, n);
    chk(n, 5);
    wr(MF, 32'h2);
    wr(GP, 32'h1);
    gap(1'b0, n);
    chk(n, 0);
    // Upper prescaler bits are set on purpose: the card clock must ignore them.
    wr(GP, 32'hE3);
    wr(MF, 32'h20);
    gap(1'b1, n);
    chk(n, 6);
    wr(GP, 32'h1F);
    gap(1'b1, n);
    chk(n, 62);
    endt(6);
    wr(GP, 32'h0301);
    tc_gap(n);
    chk(n, 3 * BAUD);
    wr(GP, 32'h0001);
    tc_gap(n);
    chk(n, 1);
    wr(MF, 32'h0);
    wr(GP, 32'h0501);
    tc_gap(n);
    chk(n, 1);
    chk(32'(irq), 32'h1);
    wr(IE, 32'h3);
    chk(32'(irq), 32'h0);
    wr(IC, 32'h4);
    rc(IS, 32'h0);
    endt(7);
    complete_run();
  end
endmodule
`default_nettype wire
